// ==== hdl/csic_defs.svh ====
// Offsets, field positions, reset values and timing counts for the
// core status / timer config / interrupt control register bank.
// Assumes byte addressing on a 32-bit AXI4-Lite bus, one word each.
`ifndef CSIC_DEFS_SVH
`define CSIC_DEFS_SVH

// Register byte offsets
`define CSIC_OFS_STATUS   8'h00
`define CSIC_OFS_TCONFIG  8'h04
`define CSIC_OFS_IRQCTL   8'h08
`define CSIC_OFS_TCOUNT   8'h0c
`define CSIC_OFS_PCMASK   8'h10

// Core status fields
`define CSIC_ST_IND_PAGE  7
`define CSIC_ST_UPPER_BK  6
`define CSIC_ST_BANK      5
`define CSIC_ST_WDT_EXP   4
`define CSIC_ST_PWR_DN    3
`define CSIC_ST_ZERO      2
`define CSIC_ST_HCARRY    1
`define CSIC_ST_CARRY     0

// Timer config fields
`define CSIC_TC_PU_DIS    7
`define CSIC_TC_EXT_EDGE  6
`define CSIC_TC_SRC_SEL   5
`define CSIC_TC_EDGE_SEL  4
`define CSIC_TC_PS_OWNER  3

// Interrupt control fields
`define CSIC_IC_GIE       7
`define CSIC_IC_PERIPHERAL_IRQ_ENABLE      6
`define CSIC_IC_T0_EN     5
`define CSIC_IC_EXT_EN    4
`define CSIC_IC_PC_EN     3
`define CSIC_IC_T0_FLAG   2
`define CSIC_IC_EXT_FLAG  1
`define CSIC_IC_PC_FLAG   0

// Reset values
`define CSIC_STATUS_RST   8'h18
`define CSIC_TCONFIG_RST  8'hff
`define CSIC_IRQCTL_RST   8'h00
`define CSIC_PCMASK_RST   6'h00

// Instruction cycle is the core clock divided by this
`define CSIC_INSTR_DIV    4

`endif

// ==== hdl/csic_pkg.sv ====
// Types shared by the core status / interrupt control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package csic_pkg;
    // Operations the execution datapath asks this bank to evaluate
    typedef enum logic [2:0] {
        CSIC_OP_ADD,
        CSIC_OP_SUB,
        CSIC_OP_AND,
        CSIC_OP_ROT_R,
        CSIC_OP_ROT_L
    } csic_alu_op_t;

    // AXI response codes
    typedef enum logic [1:0] {
        CSIC_RESP_OKAY   = 2'b00,
        CSIC_RESP_SLVERR = 2'b10
    } csic_resp_t;
endpackage

// ==== hdl/csic_core_regs.sv ====
// Core status, timer/watchdog config and interrupt control bank.
// Assumes one clock, sync active-low reset, AXI4-Lite master on the bus,
// core events arriving as one-cycle pulses on aclk, pins asynchronous.
//
// Contract
// - Bank bit selects upper or lower direct half
// - Expiry flag set by power-up, kick, sleep; cleared timeout
// - Power-down flag set power-up, kick; cleared by sleep
// - Zero flag follows whether the result is zero
// - Half-carry is carry out of bit three
// - Carry is carry out of top bit
// - Rotates load carry with bit shifted out
// - Pull-up disable forces every pull-up off
// - Edge select picks rising or falling external edge
// - Source select picks timer pin or instruction clock
// - Edge select picks falling or rising timer pin edge
// - Owner bit attaches prescaler to watchdog or timer
// - Ratio divides timer by 2^(n+1), watchdog 2^n
// - Flags set regardless of any enable bit
// - Request needs flag, enable, global (and peripheral) enable
// - Timer overflow flag set on rollover, sticky
// - Reset leaves timer count unchanged
// - External flag set on selected edge, sticky
// - Port-change flag set on masked pin change, sticky
// - Flag-affecting instruction overrides status flag writes
// - Expiry and power-down flags ignore all writes
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`include "csic_defs.svh"

module csic_core_regs #(
    parameter int PORT_PINS = 6
) (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Execution datapath
    input  wire logic                 alu_valid,
    input  wire csic_pkg::csic_alu_op_t alu_op,
    input  wire logic [7:0]           alu_a,
    input  wire logic [7:0]           alu_b,
    output logic [7:0]                alu_result,
    input  wire logic                 watchdog_kick_instr,
    input  wire logic                 sleep_instr,
    input  wire logic [6:0]           direct_addr,
    output logic [7:0]                bank_addr,
    // Watchdog side
    input  wire logic                 wdt_base_tick,
    input  wire logic                 wdt_timeout,
    output logic                      wdt_scaled_tick,
    // Pins and port
    input  wire logic                 ext_irq_pin,
    input  wire logic                 timer_clock_pin,
    input  wire logic [PORT_PINS-1:0] port_pins,
    input  wire logic [PORT_PINS-1:0] port_latch,
    output logic [PORT_PINS-1:0]      pullup_en,
    // Interrupt out to the core
    input  wire logic                 periph_irq_pending,
    output logic                      irq_request
);
    import csic_pkg::*;

    localparam int SW = PORT_PINS + 2;  // Synchronised pin count

    // Register state
    logic [7:0]           core_status_reg;   // Flags and bank select
    logic [7:0]           timer_config_reg;  // Timer/prescaler config
    logic [7:0]           irq_control_reg;   // Enables and flags
    logic [7:0]           timer_zero_count;  // No reset on purpose
    logic [PORT_PINS-1:0] pin_change_mask_reg;

    // AXI holding state
    logic       aw_held;    // Write address captured
    logic       w_held;     // Write data captured
    logic [7:0] aw_addr;    // Captured write address
    logic [7:0] w_data;     // Captured low byte
    logic       w_lane0;    // Low byte lane enabled

    // AXI handshakes; one write and one read outstanding at most
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read  = s_axi_arvalid && s_axi_arready;

    // Write decode
    wire wsel_status = aw_addr == `CSIC_OFS_STATUS;
    wire wsel_tcfg   = aw_addr == `CSIC_OFS_TCONFIG;
    wire wsel_irq    = aw_addr == `CSIC_OFS_IRQCTL;
    wire wsel_count  = aw_addr == `CSIC_OFS_TCOUNT;
    wire wsel_mask   = aw_addr == `CSIC_OFS_PCMASK;
    wire wsel_hit    = wsel_status || wsel_tcfg || wsel_irq ||
                       wsel_count || wsel_mask;
    wire wr_en       = do_write && w_lane0;
    wire wr_status   = wr_en && wsel_status;
    wire wr_tcfg     = wr_en && wsel_tcfg;
    wire wr_irq      = wr_en && wsel_irq;
    wire wr_count    = wr_en && wsel_count;
    wire wr_mask     = wr_en && wsel_mask;

    // Read decode; unmapped reads return zero with SLVERR
    wire rsel_status = s_axi_araddr == `CSIC_OFS_STATUS;
    wire rsel_tcfg   = s_axi_araddr == `CSIC_OFS_TCONFIG;
    wire rsel_irq    = s_axi_araddr == `CSIC_OFS_IRQCTL;
    wire rsel_count  = s_axi_araddr == `CSIC_OFS_TCOUNT;
    wire rsel_mask   = s_axi_araddr == `CSIC_OFS_PCMASK;
    wire rsel_hit    = rsel_status || rsel_tcfg || rsel_irq ||
                       rsel_count || rsel_mask;
    wire [7:0] rd_byte =
        rsel_status ? core_status_reg :
        rsel_tcfg   ? timer_config_reg :
        rsel_irq    ? irq_control_reg :
        rsel_count  ? timer_zero_count :
        rsel_mask   ? 8'(pin_change_mask_reg) : 8'h00;

    // Address/data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wsel_hit ? CSIC_RESP_OKAY : CSIC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read data, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rsel_hit ? CSIC_RESP_OKAY : CSIC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Flag arithmetic; subtract adds the two's complement of b
    wire       is_sub   = alu_op == CSIC_OP_SUB;
    wire [7:0] b_oper   = is_sub ? ~alu_b : alu_b;
    wire [8:0] alu_sum  = 9'(alu_a) + 9'(b_oper) + 9'(is_sub);
    wire [4:0] nib_sum  = 5'(alu_a[3:0]) + 5'(b_oper[3:0]) +
                          5'(is_sub);
    wire       old_c    = core_status_reg[`CSIC_ST_CARRY];
    wire [7:0] next_alu_result =
        (alu_op == CSIC_OP_ADD || is_sub) ? alu_sum[7:0] :
        (alu_op == CSIC_OP_AND)   ? (alu_a & alu_b) :
        (alu_op == CSIC_OP_ROT_R) ? {old_c, alu_a[7:1]} :
        (alu_op == CSIC_OP_ROT_L) ? {alu_a[6:0], old_c} : alu_a;
    wire arith    = alu_valid && (alu_op == CSIC_OP_ADD || is_sub);
    wire upd_zero = arith || (alu_valid && alu_op == CSIC_OP_AND);
    wire upd_rot  = alu_valid &&
                    (alu_op == CSIC_OP_ROT_R || alu_op == CSIC_OP_ROT_L);
    wire alu_zero = next_alu_result == 8'h00;
    wire rot_out  = (alu_op == CSIC_OP_ROT_R) ? alu_a[0] : alu_a[7];

    // Next core status; instruction flags beat a bus write
    wire [7:0] next_status;
    assign next_status[7:5] = wr_status ? w_data[7:5]
                                        : core_status_reg[7:5];
    // Timeout wins over a kick landing in the same cycle
    assign next_status[`CSIC_ST_WDT_EXP] =
        wdt_timeout ? 1'b0 :
        (watchdog_kick_instr || sleep_instr) ? 1'b1 :
        core_status_reg[`CSIC_ST_WDT_EXP];
    assign next_status[`CSIC_ST_PWR_DN] =
        watchdog_kick_instr ? 1'b1 :
        sleep_instr ? 1'b0 : core_status_reg[`CSIC_ST_PWR_DN];
    assign next_status[`CSIC_ST_ZERO] =
        upd_zero  ? alu_zero :
        wr_status ? w_data[`CSIC_ST_ZERO]
                  : core_status_reg[`CSIC_ST_ZERO];
    assign next_status[`CSIC_ST_HCARRY] =
        arith     ? nib_sum[4] :
        wr_status ? w_data[`CSIC_ST_HCARRY]
                  : core_status_reg[`CSIC_ST_HCARRY];
    assign next_status[`CSIC_ST_CARRY] =
        arith     ? alu_sum[8] :
        upd_rot   ? rot_out :
        wr_status ? w_data[`CSIC_ST_CARRY] : old_c;

    // Status and datapath result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_status_reg <= `CSIC_STATUS_RST;
            alu_result      <= 8'h00;
        end else begin
            core_status_reg <= next_status;
            if (alu_valid) begin
                alu_result <= next_alu_result;
            end
        end
    end

    // Direct addressing picks the bank half
    assign bank_addr = {core_status_reg[`CSIC_ST_BANK], direct_addr};

    // Timer config and pin-change mask, plain storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_config_reg    <= `CSIC_TCONFIG_RST;
            pin_change_mask_reg <= `CSIC_PCMASK_RST;
        end else begin
            if (wr_tcfg) begin
                timer_config_reg <= w_data;
            end
            if (wr_mask) begin
                pin_change_mask_reg <= w_data[PORT_PINS-1:0];
            end
        end
    end

    // Pull-ups follow the latches unless globally disabled
    assign pullup_en = timer_config_reg[`CSIC_TC_PU_DIS] ?
                       '0 : port_latch;

    // Two-stage pin synchroniser plus one history stage for edges
    // Unreset: zeroed history would fake an edge on a high pin
    logic [SW-1:0] pin_meta;    // First stage, read only by pin_sync
    logic [SW-1:0] pin_sync;    // Safe to use
    logic [SW-1:0] pin_prev;    // Previous safe sample
    always_ff @(posedge aclk) begin
        pin_meta <= {timer_clock_pin, ext_irq_pin, port_pins};
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end

    // Per-pin change detect, gated by the mask
    logic [PORT_PINS-1:0] pin_changed;
    for (genvar i = 0; i < PORT_PINS; i++) begin : g_pc
        assign pin_changed[i] = pin_change_mask_reg[i] &&
                                (pin_sync[i] ^ pin_prev[i]);
    end
    wire port_change = |pin_changed;

    // External pin edge per edge select
    wire ext_now  = pin_sync[PORT_PINS];
    wire ext_was  = pin_prev[PORT_PINS];
    wire ext_edge = timer_config_reg[`CSIC_TC_EXT_EDGE] ?
                    (ext_now && !ext_was) : (!ext_now && ext_was);

    // Timer pin edge per edge select; 1 means falling
    wire tpin_now  = pin_sync[PORT_PINS+1];
    wire tpin_was  = pin_prev[PORT_PINS+1];
    wire tpin_edge = timer_config_reg[`CSIC_TC_EDGE_SEL] ?
                     (!tpin_now && tpin_was) :
                     (tpin_now && !tpin_was);

    // Instruction cycle tick at a quarter of the core clock
    logic [1:0] instr_div;
    wire instr_tick = instr_div == 2'(`CSIC_INSTR_DIV - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_div <= 2'b00;
        end else begin
            instr_div <= instr_div + 2'b01;
        end
    end

    // Timer source select
    wire t0_src = timer_config_reg[`CSIC_TC_SRC_SEL] ?
                  tpin_edge : instr_tick;

    // Shared prescaler; owner bit routes it
    wire       ps_wdt   = timer_config_reg[`CSIC_TC_PS_OWNER];
    wire [2:0] ps_n     = timer_config_reg[2:0];
    wire       ps_in    = ps_wdt ? wdt_base_tick : t0_src;
    logic [7:0] ps_cnt;                 // Prescaler ripple count
    wire [7:0] mask_t0  = 8'((9'h002 << ps_n) - 9'h001);
    wire [7:0] mask_wdt = 8'((9'h001 << ps_n) - 9'h001);
    wire [7:0] ps_mask  = ps_wdt ? mask_wdt : mask_t0;
    wire       ps_due   = ps_in && ((ps_cnt & ps_mask) == ps_mask);

    // Unowned side runs undivided, so the watchdog never stalls
    wire t0_inc = ps_wdt ? t0_src : ps_due;
    assign wdt_scaled_tick = ps_wdt ? ps_due : wdt_base_tick;

    // Prescaler clears on a count write while the timer owns it, so the next period is whole
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps_cnt <= 8'h00;
        end else if (wr_count && !ps_wdt) begin
            ps_cnt <= 8'h00;
        end else if (ps_in) begin
            ps_cnt <= ps_cnt + 8'h01;
        end
    end

    // Timer count keeps its value through reset
    always_ff @(posedge aclk) begin
        if (wr_count) begin
            timer_zero_count <= w_data;
        end else if (t0_inc) begin
            timer_zero_count <= timer_zero_count + 8'h01;
        end
    end
    wire t0_roll = t0_inc && !wr_count &&
                   timer_zero_count == 8'hff;

    // Flags: hardware set beats a software clear in the same cycle
    wire [2:0] flag_hw  = {t0_roll, ext_edge, port_change};
    wire [2:0] flag_cur = irq_control_reg[2:0];
    wire [2:0] flag_sw  = wr_irq ? w_data[2:0] : flag_cur;
    wire [7:0] next_irq_control = {
        wr_irq ? w_data[7:3] : irq_control_reg[7:3],
        flag_sw | flag_hw
    };
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_control_reg <= `CSIC_IRQCTL_RST;
        end else begin
            irq_control_reg <= next_irq_control;
        end
    end

    // Request to the core
    wire t0_req  = irq_control_reg[`CSIC_IC_T0_EN] &&
                   irq_control_reg[`CSIC_IC_T0_FLAG];
    wire ext_req = irq_control_reg[`CSIC_IC_EXT_EN] &&
                   irq_control_reg[`CSIC_IC_EXT_FLAG];
    wire pc_req  = irq_control_reg[`CSIC_IC_PC_EN] &&
                   irq_control_reg[`CSIC_IC_PC_FLAG];
    wire pe_req  = irq_control_reg[`CSIC_IC_PERIPHERAL_IRQ_ENABLE] && periph_irq_pending;
    assign irq_request = irq_control_reg[`CSIC_IC_GIE] &&
                         (t0_req || ext_req || pc_req || pe_req);

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_bank_map;
        bank_addr[7] == core_status_reg[`CSIC_ST_BANK];
    endproperty
    a_bank_map: assert property (p_bank_map)
        else $error("bank half does not follow bank select");

    sequence s_timeout;
        wdt_timeout;
    endsequence
    property p_wdt_exp;
        s_timeout |=> !core_status_reg[`CSIC_ST_WDT_EXP];
    endproperty
    a_wdt_exp: assert property (p_wdt_exp)
        else $error("expiry flag not cleared by timeout");

    property p_pwr_dn;
        sleep_instr && !watchdog_kick_instr
            |=> !core_status_reg[`CSIC_ST_PWR_DN];
    endproperty
    a_pwr_dn: assert property (p_pwr_dn)
        else $error("power-down flag not cleared by sleep");

    property p_carry;
        arith |=> core_status_reg[`CSIC_ST_CARRY] == $past(alu_sum[8]);
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry does not match sum carry");

    property p_zero;
        arith |=> core_status_reg[`CSIC_ST_ZERO] ==
                  (alu_result == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag disagrees with result");

    property p_rot_r;
        alu_valid && alu_op == CSIC_OP_ROT_R
            |=> core_status_reg[`CSIC_ST_CARRY] == $past(alu_a[0]);
    endproperty
    a_rot_r: assert property (p_rot_r)
        else $error("rotate right did not load carry");

    property p_pullup;
        timer_config_reg[`CSIC_TC_PU_DIS] |-> pullup_en == '0;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up on while disabled");

    property p_irq_gate;
        irq_request |-> irq_control_reg[`CSIC_IC_GIE];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request without global enable");

    property p_t0_roll;
        t0_roll |=> irq_control_reg[`CSIC_IC_T0_FLAG] &&
                    timer_zero_count == 8'h00;
    endproperty
    a_t0_roll: assert property (p_t0_roll)
        else $error("rollover did not set the timer flag");

    property p_flag_clear;
        $fell(irq_control_reg[`CSIC_IC_EXT_FLAG]) |-> $past(wr_irq);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("external flag fell without a write");
endmodule

// ==== dv/csic_dp_model.sv ====
// Datapath stand-in: one-cycle ALU requests, kick and sleep pulses.
// Assumes the bank samples every request on the rising aclk edge.
module csic_dp_model (
    // Clock
    input  wire logic            aclk,
    // Requests to the bank
    output csic_pkg::csic_alu_op_t alu_op,
    output logic                 alu_valid,
    output logic [7:0]           alu_a,
    output logic [7:0]           alu_b,
    output logic                 watchdog_kick_instr,
    output logic                 sleep_instr,
    output logic [6:0]           direct_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    import csic_pkg::*;
    initial begin
        alu_op = CSIC_OP_ADD;
        alu_valid = 1'b0;
        alu_a = 8'h00;
        alu_b = 8'h00;
        watchdog_kick_instr = 1'b0;
        sleep_instr = 1'b0;
        direct_addr = 7'h00;
    end
    // Walking address so bank bit is seen against many offsets
    always @(posedge aclk) begin
        direct_addr <= direct_addr + 7'h05;
    end
    // One request; operand a scrambled once released
    task automatic op(input csic_alu_op_t o, input logic [7:0] a,
                      input logic [7:0] b);
        @(posedge aclk);
        alu_op <= o;
        alu_a <= a;
        alu_b <= b;
        alu_valid <= 1'b1;
        @(posedge aclk);
        alu_valid <= 1'b0;
        alu_a <= ~a;
    endtask
    // Kick when k is high, otherwise sleep
    task automatic ev(input logic k);
        @(posedge aclk);
        watchdog_kick_instr <= k;
        sleep_instr <= ~k;
        @(posedge aclk);
        watchdog_kick_instr <= 1'b0;
        sleep_instr <= 1'b0;
    endtask
endmodule

// ==== dv/core_status_irq_control_tb_top.sv ====
// Self-checking bench for the status / timer / interrupt register bank.
// Assumes the design and datapath model are compiled before it.
`include "csic_defs.svh"
module core_status_irq_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csic_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0, wdt_timeout = 1'b0, ext_irq_pin = 1'b0;
    logic timer_clock_pin = 1'b0, wdt_base_tick = 1'b0;
    logic periph_irq_pending = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [5:0] port_pins = 6'h00, port_latch = 6'h00, pullup_en;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, wdt_scaled_tick, irq_request, alu_valid;
    logic watchdog_kick_instr, sleep_instr;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] alu_a, alu_b, alu_result, bank_addr, st;
    logic [6:0] direct_addr;
    csic_alu_op_t alu_op;
    logic [33:0] exp_q[$];
    int errors = 0, samples_checked = 0, cyc = 0, seed = 32'h1b482d05;
    always #2 aclk = ~aclk;
    csic_core_regs i_dut (.*);
    csic_dp_model i_dp (.*);
    task automatic check(input logic [33:0] seen, input logic [33:0] e);
        samples_checked++;
        if (seen !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, e);
        end
    endtask
    // Oldest note against each completed bus response
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, exp_q.pop_front());
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        exp_q.push_back(34'h0);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad = ad | (s_axi_awvalid & s_axi_awready);
            dd = dd | (s_axi_wvalid & s_axi_wready);
            s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] r = 2'b00);
        exp_q.push_back({r, 24'h0, v});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Expected status after one datapath operation
    function automatic logic [7:0] flags(input csic_alu_op_t o,
        input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] m;
        m = (o == CSIC_OP_SUB) ? ~b : b;
        r = {1'b0, a} + {1'b0, m} + 9'(o == CSIC_OP_SUB);
        h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(o == CSIC_OP_SUB);
        flags = s;
        case (o)
            CSIC_OP_ROT_R: flags[0] = a[0];
            CSIC_OP_ROT_L: flags[0] = a[7];
            CSIC_OP_AND: flags[2] = ((a & b) == 8'h00);
            default: flags[2:0] = {r[7:0] == 8'h00, h[4], r[8]};
        endcase
    endfunction
    task automatic results();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        csic_alu_op_t o;
        logic [7:0] a, b, r;
        logic [3:0] n;
        port_latch = 6'($random(seed));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        st = `CSIC_STATUS_RST;
        check(pullup_en, 6'h00);
        rd(`CSIC_OFS_STATUS, st);
        rd(`CSIC_OFS_TCONFIG, `CSIC_TCONFIG_RST);
        rd(`CSIC_OFS_IRQCTL, `CSIC_IRQCTL_RST);
        rd(8'h14, 8'h00, 2'b10);
        for (int i = 0; i < 12; i++) begin
            o = csic_alu_op_t'(3'(i % 5));
            a = (i == 0) ? 8'h88 : 8'($random(seed));
            b = (i == 0) ? 8'h78 : (i == 1) ? a : 8'($random(seed));
            i_dp.op(o, a, b);
            r = (o == CSIC_OP_AND) ? a & b :
                (o == CSIC_OP_ROT_R) ? {st[0], a[7:1]} :
                (o == CSIC_OP_ROT_L) ? {a[6:0], st[0]} :
                (o == CSIC_OP_SUB) ? a - b : a + b;
            st = flags(o, a, b, st);
            rd(`CSIC_OFS_STATUS, st);
            check(alu_result, r);
        end
        for (int k = 0; k < 2; k++) begin
            wr(`CSIC_OFS_STATUS, {2'b00, k[0], 5'h07});
            st = {2'b00, k[0], st[4:3], 3'h7};
            rd(`CSIC_OFS_STATUS, st);
            @(negedge aclk);
            check(bank_addr, {k[0], direct_addr});
        end
        i_dp.ev(1'b0);
        st[4:3] = 2'b10;
        rd(`CSIC_OFS_STATUS, st);
        wdt_timeout <= 1'b1;
        @(posedge aclk);
        wdt_timeout <= 1'b0;
        st[4] = 1'b0;
        rd(`CSIC_OFS_STATUS, st);
        i_dp.ev(1'b1);
        rd(`CSIC_OFS_STATUS, st | 8'h18);
        // Timer held on the idle pin so only the wanted flags move
        for (int e = 1; e >= 0; e--) begin
            wr(`CSIC_OFS_TCONFIG, {1'b0, e[0], 6'h28});
            wr(`CSIC_OFS_IRQCTL, 8'h00);
            ext_irq_pin <= e[0];
            repeat (5) @(posedge aclk);
            check(irq_request, 1'b0);
            rd(`CSIC_OFS_IRQCTL, 8'h02);
            wr(`CSIC_OFS_IRQCTL, 8'h92);
            @(negedge aclk);
            check(irq_request, 1'b1);
            check(pullup_en, port_latch);
        end
        wr(`CSIC_OFS_IRQCTL, 8'hc0);
        periph_irq_pending <= 1'b1;
        @(negedge aclk);
        check(irq_request, 1'b1);
        wr(`CSIC_OFS_PCMASK, 8'h01);
        wr(`CSIC_OFS_IRQCTL, 8'h00);
        port_pins <= 6'h02;
        repeat (5) @(posedge aclk);
        rd(`CSIC_OFS_IRQCTL, 8'h00);
        port_pins <= 6'h03;
        repeat (5) @(posedge aclk);
        rd(`CSIC_OFS_IRQCTL, 8'h01);
        for (int p = 0; p < 2; p++) begin
            wr(`CSIC_OFS_TCOUNT, 8'hf0);
            wr(`CSIC_OFS_TCONFIG, p ? 8'h00 : 8'h08);
            wr(`CSIC_OFS_IRQCTL, 8'h00);
            repeat (80) @(posedge aclk);
            rd(`CSIC_OFS_IRQCTL, p ? 8'h00 : 8'h04);
        end
        repeat (80) @(posedge aclk);
        rd(`CSIC_OFS_IRQCTL, 8'h04);
        wr(`CSIC_OFS_TCONFIG, 8'h0a);
        n = 4'h0;
        wdt_base_tick <= 1'b1;
        repeat (8) begin
            @(posedge aclk);
            n += 4'(wdt_scaled_tick);
        end
        wdt_base_tick <= 1'b0;
        check(n, 4'h2);
        wr(`CSIC_OFS_TCONFIG, 8'h28);
        wr(`CSIC_OFS_TCOUNT, 8'h5a);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CSIC_OFS_TCOUNT, 8'h5a);
        results();
    end
endmodule
